// ### shared/mbs_pkg.sv
/*
  Constants, pin bit positions and state codes for the module boot
  select glue. Assumes a single 40 MHz clock shared by all users.
*/
package mbs_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS       = 25;
  localparam int RESET_HOLD_NS       = 500;
  // Least time, so round up
  localparam int RESET_HOLD_CYCLES   =
    (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Flushed filter shows a held strap after four edges; catch on the fifth
  localparam int STRAP_SETTLE_CYCLES = 5;

  localparam logic [4:0] RESET_CNT_LOAD  = 5'(RESET_HOLD_CYCLES);
  localparam logic [2:0] SETTLE_CNT_LOAD = 3'(STRAP_SETTLE_CYCLES);

  // ------------------------------------------------------------
  // Synchronised pin vector
  // ------------------------------------------------------------
  localparam int PIN_WIDTH = 9;
  localparam int PIN_MRST  = 0;
  localparam int PIN_WAKE  = 1;
  localparam int PIN_STBY  = 2;
  localparam int PIN_SUSP  = 3;
  localparam int PIN_BOOT  = 4;
  localparam int PIN_ABORT = 5;
  localparam int PIN_DEBUG = 6;
  localparam int PIN_ACT   = 7;
  localparam int PIN_LINK  = 8;
  // Idle levels: requests high, straps at their pulled levels
  localparam logic [8:0] PIN_INIT = 9'h03f;

  // ------------------------------------------------------------
  // Values after reset
  // ------------------------------------------------------------
  localparam logic BOOT_STRAP_RESET  = 1'b1;
  localparam logic DEBUG_STRAP_RESET = 1'b0;

  typedef enum logic [2:0]
  {
    MBS_RUN     = 3'b001,
    MBS_SUSPEND = 3'b010,
    MBS_STANDBY = 3'b100
  } mbs_power_type;

endpackage

// ### design/mbs_pin_sync.sv
/*
  Three-stage synchroniser for a vector of board pins with a two-stage
  agreement filter. Assumes pins are asynchronous to clk.
*/
module mbs_pin_sync
  import mbs_pkg::*;
#(
  parameter int         WIDTH = PIN_WIDTH,
  parameter logic [8:0] INIT  = PIN_INIT
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // ------------------------------------------------------------
  // Filter
  // ------------------------------------------------------------
  // Take a new level only once stages two and three agree
  assign next_level = (stage2 & stage3) | (pin_level & (stage2 ^ stage3));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stage1    <= INIT[WIDTH-1:0];
      stage2    <= INIT[WIDTH-1:0];
      stage3    <= INIT[WIDTH-1:0];
      pin_level <= INIT[WIDTH-1:0];
    end
    else
    begin
      stage1    <= pin_in;
      stage2    <= stage1;
      stage3    <= stage2;
      pin_level <= next_level;
    end
  end

endmodule

// ### design/mbs_glue.sv
/*
  Board glue of a processor module: boot select steering, wait merge,
  reset fan-out, power requests, area selects and network LEDs.
  Assumes the local bus selects and strobes come from the processor on
  clk; straps, requests and PHY indications are asynchronous pins.
*/
// Function
// - Strap low: boot ROM select follows the area-zero select.
// - Strap high: boot ROM select idle; onboard flash takes area zero.
// - Strap zero means external boot, one onboard; floating means onboard.
// - Master reset low drives the internal reset out to all peripherals.
// - Card ready low pulls the bus wait line low to stretch cycles.
// - Wake request returns Suspend or Standby to Run; also drives IRQ C.
// - Standby request enters power-down with SDRAM self-refresh until wake.
// - Fast peripheral select follows local bus select 4.
// - Slow peripheral select follows local bus select 5.
// - Video area select follows local bus select 3.
// - Select 2 reaches NAND flash, select 1 the memory card.
// - Activity LED low while sending, receiving or colliding.
// - Link LED low while valid link pulses are present.
// - Debug strap low picks background debug, high boundary scan.
// - Script abort strap is readable as a general-purpose input.
// - Write strobe low while valid write data is on the bus.
module mbs_glue
  import mbs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       local_bus_select_0_n,
  input  wire logic       local_bus_select_1_n,
  input  wire logic       local_bus_select_2_n,
  input  wire logic       local_bus_select_3_n,
  input  wire logic       local_bus_select_4_n,
  input  wire logic       local_bus_select_5_n,
  input  wire logic       transfer_ack_n,
  input  wire logic       card_channel_ready_n,
  input  wire logic       byte_lane_write_1_n,
  input  wire logic       boot_source_strap,
  input  wire logic       script_abort_strap,
  input  wire logic       debug_mode_strap,
  input  wire logic       master_reset_n,
  input  wire logic       wake_request_n,
  input  wire logic       standby_request_n,
  input  wire logic       suspend_request_n,
  input  wire logic       internal_wake,
  input  wire logic       phy_tx_active,
  input  wire logic       phy_rx_active,
  input  wire logic       phy_collision,
  input  wire logic       phy_link_ok,
  output logic            boot_rom_select_n,
  output logic            onboard_flash_select_n,
  output logic            card_area_select_n,
  output logic            nand_flash_select_n,
  output logic            video_area_select_n,
  output logic            fast_area_select_n,
  output logic            slow_area_select_n,
  output logic            bus_cycle_wait_n,
  output logic            io_write_strobe_n,
  output logic            irq_line_c_n,
  output logic            internal_reset_out_n,
  output logic [2:0]      power_state,
  output logic            sdram_self_refresh,
  output logic            net_activity_led_n,
  output logic            net_link_led_n,
  output logic            debug_scan_mode,
  output logic            script_abort_value
);

  function automatic logic falling(input logic prev, input logic cur);
    falling = prev & ~cur;
  endfunction

  logic [8:0]    pin_raw;
  logic [8:0]    pin_level;
  wire logic     mrst_level  = pin_level[PIN_MRST];
  wire logic     wake_level  = pin_level[PIN_WAKE];
  wire logic     stby_level  = pin_level[PIN_STBY];
  wire logic     susp_level  = pin_level[PIN_SUSP];
  wire logic     boot_level  = pin_level[PIN_BOOT];
  wire logic     debug_level = pin_level[PIN_DEBUG];
  logic          boot_onboard;
  logic [2:0]    settle_cnt;
  logic [4:0]    reset_cnt;
  logic          stby_prev;
  logic          susp_prev;
  mbs_power_type state;
  mbs_power_type next_state;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  assign pin_raw = {phy_link_ok,
                    phy_tx_active | phy_rx_active | phy_collision,
                    debug_mode_strap, script_abort_strap, boot_source_strap,
                    suspend_request_n, standby_request_n, wake_request_n,
                    master_reset_n};

  mbs_pin_sync #(.WIDTH(PIN_WIDTH), .INIT(PIN_INIT)) u_pin_sync
  (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (pin_raw),
    .pin_level (pin_level)
  );

  // ------------------------------------------------------------
  // Boot steering
  // ------------------------------------------------------------
  // boot ROM takes area zero on external boot, onboard flash on onboard boot
  assign boot_rom_select_n = boot_onboard ? 1'b1 : local_bus_select_0_n;
  assign onboard_flash_select_n = boot_onboard ? local_bus_select_0_n : 1'b1;

  // strap caught once settled; defaults onboard
  // debug mode caught with the boot strap
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      settle_cnt      <= SETTLE_CNT_LOAD;
      boot_onboard    <= BOOT_STRAP_RESET;
      debug_scan_mode <= DEBUG_STRAP_RESET;
    end
    else
    begin
      if (settle_cnt != 3'h0)
        settle_cnt <= settle_cnt - 3'h1;
      if (settle_cnt == 3'h1)
      begin
        boot_onboard    <= boot_level;
        debug_scan_mode <= debug_level;
      end
    end
  end

  // ------------------------------------------------------------
  // Area selects and bus strobes
  // ------------------------------------------------------------
  // memory card and NAND flash areas
  assign card_area_select_n  = local_bus_select_1_n;
  assign nand_flash_select_n = local_bus_select_2_n;
  assign video_area_select_n = local_bus_select_3_n;
  assign fast_area_select_n  = local_bus_select_4_n;
  assign slow_area_select_n  = local_bus_select_5_n;
  // card ready stretches the bus cycle
  assign bus_cycle_wait_n    = transfer_ack_n & card_channel_ready_n;
  // lane 1 write enable doubles as write strobe
  assign io_write_strobe_n   = byte_lane_write_1_n;
  // wake pin also reaches IRQ C
  assign irq_line_c_n        = wake_request_n;

  // ------------------------------------------------------------
  // Reset fan-out
  // ------------------------------------------------------------
  // hold peripherals in reset, stretched past release
  always_ff @(posedge clk)
  begin
    if (rst || !mrst_level)
    begin
      reset_cnt            <= RESET_CNT_LOAD;
      internal_reset_out_n <= 1'b0;
    end
    else
    begin
      if (reset_cnt != 5'h0)
        reset_cnt <= reset_cnt - 5'h1;
      internal_reset_out_n <= (reset_cnt == 5'h0);
    end
  end

  // ------------------------------------------------------------
  // Power state
  // ------------------------------------------------------------
  wire logic wake_on   = !wake_level || internal_wake;
  wire logic stby_edge = falling(stby_prev, stby_level);
  wire logic susp_edge = falling(susp_prev, susp_level);

  // Held wake blocks entry so a sleep never swallows a wake
  always_comb
  begin
    next_state = state;
    case (state)
      MBS_RUN:
        if (!wake_on && stby_edge)
          next_state = MBS_STANDBY;
        else if (!wake_on && susp_edge)
          next_state = MBS_SUSPEND;
      MBS_SUSPEND:
        if (wake_on)
          next_state = MBS_RUN;
        else if (stby_edge)
          next_state = MBS_STANDBY;
      MBS_STANDBY:
        if (wake_on)
          next_state = MBS_RUN;
      default:
        next_state = MBS_RUN;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst || !mrst_level)
    begin
      state              <= MBS_RUN;
      sdram_self_refresh <= 1'b0;
    end
    else
    begin
      state              <= next_state;
      sdram_self_refresh <= (next_state == MBS_STANDBY);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stby_prev <= 1'b1;
      susp_prev <= 1'b1;
    end
    else
    begin
      stby_prev <= stby_level;
      susp_prev <= susp_level;
    end
  end

  assign power_state = state;

  // ------------------------------------------------------------
  // Network LEDs and readable strap
  // ------------------------------------------------------------
  // activity and link LEDs and script abort value
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      net_activity_led_n <= 1'b1;
      net_link_led_n     <= 1'b1;
      script_abort_value <= 1'b1;
    end
    else
    begin
      net_activity_led_n <= !pin_level[PIN_ACT];
      net_link_led_n     <= !pin_level[PIN_LINK];
      script_abort_value <= pin_level[PIN_ABORT];
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [4:0] hold_run;

  always_ff @(posedge clk)
  begin
    if (rst || !mrst_level)
      hold_run <= 5'h0;
    else if (hold_run != 5'h1f)
      hold_run <= hold_run + 5'h1;
  end

  sequence seq_standby_req;
    (state != MBS_STANDBY) && stby_edge && !wake_on && mrst_level;
  endsequence

  sequence seq_wake_req;
    (state != MBS_RUN) && wake_on && mrst_level;
  endsequence

  a_boot_external: assert property (
    !boot_onboard |-> boot_rom_select_n == local_bus_select_0_n
                      && onboard_flash_select_n)
    else $error("boot select does not follow area zero");

  a_boot_onboard: assert property (
    boot_onboard |-> boot_rom_select_n
                     && onboard_flash_select_n == local_bus_select_0_n)
    else $error("boot select active with onboard boot");

  a_strap_capture: assert property (
    (settle_cnt == 3'h1) |=> boot_onboard == $past(boot_level)
                             && debug_scan_mode == $past(debug_level))
    else $error("strap not captured");

  a_reset_held: assert property (
    (hold_run < 5'd20) |=> !internal_reset_out_n)
    else $error("internal reset released early");

  a_reset_release: assert property (
    (hold_run == 5'd20) && mrst_level |=> internal_reset_out_n)
    else $error("internal reset not released");

  a_wait_merge: assert property (
    !card_channel_ready_n |-> !bus_cycle_wait_n)
    else $error("card ready did not stretch cycle");

  a_wake_run: assert property (
    seq_wake_req |=> state == MBS_RUN && !sdram_self_refresh)
    else $error("wake did not return to run");

  a_standby_entry: assert property (
    seq_standby_req |=> state == MBS_STANDBY && sdram_self_refresh)
    else $error("standby not entered");

  a_area_selects: assert property (
    fast_area_select_n == local_bus_select_4_n
    && slow_area_select_n == local_bus_select_5_n
    && video_area_select_n == local_bus_select_3_n)
    else $error("area select mismatch");

  a_led_activity: assert property (
    pin_level[PIN_ACT] |=> !net_activity_led_n ##1 1'b1)
    else $error("activity LED not lit");

endmodule

// ### tb/mbs_board_model.sv
/*
  Baseboard model: memory card ready line and the two mode straps.
  Assumes the card select comes from the glue block and the clock from the bench.
*/
module mbs_board_model
(
  input  wire logic       clk,
  input  wire logic       card_area_select_n,
  input  wire logic [3:0] card_hold,
  input  wire logic [1:0] boot_drive,
  input  wire logic [1:0] debug_drive,
  output logic            card_channel_ready_n,
  output logic            boot_source_strap,
  output logic            debug_mode_strap
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] busy_cycles;

  // ------------------------------------------------------------
  // Card wait
  // ------------------------------------------------------------
  // card needs more time
  always_ff @(posedge clk)
  begin
    if (card_area_select_n)
      busy_cycles <= 4'h0;
    else if (busy_cycles < card_hold)
      busy_cycles <= busy_cycles + 4'h1;
  end
  assign card_channel_ready_n = card_area_select_n | (busy_cycles >= card_hold);

  // ------------------------------------------------------------
  // Straps
  // ------------------------------------------------------------
  // open straps pulled
  assign boot_source_strap = boot_drive[1] ? 1'b1 : boot_drive[0];
  assign debug_mode_strap  = debug_drive[1] ? 1'b0 : debug_drive[0];
endmodule

// ### tb/tb.sv
/*
  Self-checking bench for the board glue: drives the processor side and
  the pins, notes expectations in a queue that a monitor compares.
  Assumes the board model answers for the card and the boot and debug straps.
*/
module tb
  import mbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct { int id; logic [2:0] exp; } mbs_note_type;
  mbs_note_type notes[$];
  int   errors = 0;
  int   comparisons = 0;
  event chk_ev;
  string names[17] = '{"boot_rom", "onboard", "card", "nand", "video", "fast", "slow", "wait", "iowr",
                       "irq", "int_reset", "self_refresh", "act_led", "link_led", "debug", "abort", "power"};

  logic       clk, rst, transfer_ack_n, byte_lane_write_1_n, script_abort_strap, master_reset_n;
  logic       wake_request_n, standby_request_n, suspend_request_n, internal_wake;
  logic       phy_tx_active, phy_rx_active, phy_collision, phy_link_ok;
  logic [5:0] sel;
  logic [3:0] card_hold;
  logic [1:0] boot_drive, debug_drive;
  wire logic  card_channel_ready_n, boot_source_strap, debug_mode_strap;
  wire logic  boot_rom_select_n, onboard_flash_select_n, card_area_select_n, nand_flash_select_n;
  wire logic  video_area_select_n, fast_area_select_n, slow_area_select_n, bus_cycle_wait_n;
  wire logic  io_write_strobe_n, irq_line_c_n, internal_reset_out_n, sdram_self_refresh;
  wire logic  net_activity_led_n, net_link_led_n, debug_scan_mode, script_abort_value;
  wire logic [2:0] power_state;
  wire logic [15:0] seen = {script_abort_value, debug_scan_mode, net_link_led_n, net_activity_led_n,
    sdram_self_refresh, internal_reset_out_n, irq_line_c_n, io_write_strobe_n, bus_cycle_wait_n,
    slow_area_select_n, fast_area_select_n, video_area_select_n, nand_flash_select_n,
    card_area_select_n, onboard_flash_select_n, boot_rom_select_n};

  mbs_glue mbs_glue_i (.clk(clk), .rst(rst), .local_bus_select_0_n(sel[0]), .local_bus_select_1_n(sel[1]),
    .local_bus_select_2_n(sel[2]), .local_bus_select_3_n(sel[3]), .local_bus_select_4_n(sel[4]),
    .local_bus_select_5_n(sel[5]), .transfer_ack_n(transfer_ack_n), .card_channel_ready_n(card_channel_ready_n),
    .byte_lane_write_1_n(byte_lane_write_1_n), .boot_source_strap(boot_source_strap),
    .script_abort_strap(script_abort_strap), .debug_mode_strap(debug_mode_strap),
    .master_reset_n(master_reset_n), .wake_request_n(wake_request_n), .standby_request_n(standby_request_n),
    .suspend_request_n(suspend_request_n), .internal_wake(internal_wake), .phy_tx_active(phy_tx_active),
    .phy_rx_active(phy_rx_active), .phy_collision(phy_collision), .phy_link_ok(phy_link_ok),
    .boot_rom_select_n(boot_rom_select_n), .onboard_flash_select_n(onboard_flash_select_n),
    .card_area_select_n(card_area_select_n), .nand_flash_select_n(nand_flash_select_n),
    .video_area_select_n(video_area_select_n), .fast_area_select_n(fast_area_select_n),
    .slow_area_select_n(slow_area_select_n), .bus_cycle_wait_n(bus_cycle_wait_n),
    .io_write_strobe_n(io_write_strobe_n), .irq_line_c_n(irq_line_c_n),
    .internal_reset_out_n(internal_reset_out_n), .power_state(power_state),
    .sdram_self_refresh(sdram_self_refresh), .net_activity_led_n(net_activity_led_n),
    .net_link_led_n(net_link_led_n), .debug_scan_mode(debug_scan_mode), .script_abort_value(script_abort_value));

  mbs_board_model mbs_board_model_i (.clk(clk), .card_area_select_n(card_area_select_n), .card_hold(card_hold),
    .boot_drive(boot_drive), .debug_drive(debug_drive), .card_channel_ready_n(card_channel_ready_n),
    .boot_source_strap(boot_source_strap), .debug_mode_strap(debug_mode_strap));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [2:0] obs(input int id);
    return (id == 16) ? power_state : {2'b00, seen[id]};
  endfunction

  task automatic end_of_test;
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic compare_bit(input int id, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %b seen %b", names[id], exp, got);
    end
  endtask

  task automatic compare_state(input logic [2:0] exp, input logic [2:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch power expected %h seen %h", exp, got);
    end
  endtask

  task automatic expect_out(input int id, input logic [2:0] exp);
    notes.push_back('{id, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic settle;
    @(negedge clk);
    -> chk_ev;
  endtask

  // Bounded wait; a result that never comes ends the run
  task automatic wait_for(input int id, input logic [2:0] exp, input int limit);
    int n;
    n = 0;
    while (obs(id) !== exp && n < limit)
    begin
      @(negedge clk);
      n++;
    end
    expect_out(id, exp);
    -> chk_ev;
    if (n >= limit)
    begin
      errors++;
      #1 end_of_test();
    end
  endtask

  task automatic do_reset;
    rst = 1'b1;
    tick(4);
    expect_out(10, 3'h0);
    expect_out(16, MBS_RUN);
    settle();
    tick(1);
    rst = 1'b0;
  endtask

  // ------------------------------------------------------------
  // Monitor and clock
  // ------------------------------------------------------------
  initial
  begin
    mbs_note_type note;
    forever
    begin
      @(chk_ev);
      while (notes.size() > 0)
      begin
        note = notes.pop_front();
        if (note.id == 16)
          compare_state(note.exp, power_state);
        else
          compare_bit(note.id, note.exp[0], seen[note.id]);
      end
    end
  end

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Stimulus
  // ------------------------------------------------------------
  initial
  begin
    {transfer_ack_n, byte_lane_write_1_n, script_abort_strap, master_reset_n} = 4'hf;
    {wake_request_n, standby_request_n, suspend_request_n, internal_wake} = 4'he;
    {phy_tx_active, phy_rx_active, phy_collision, phy_link_ok} = 4'h0;
    sel = 6'h3f;
    card_hold = 4'h3;
    boot_drive = 2'b00;
    debug_drive = 2'b10;
    void'($urandom(32'h3fb4));
    do_reset();
    wait_for(10, 3'h1, 40);
    repeat (24)
    begin
      tick(1);
      sel = 6'($urandom);
      byte_lane_write_1_n = 1'($urandom);
      transfer_ack_n = 1'($urandom);
      expect_out(0, {2'b00, sel[0]});
      expect_out(1, 3'h1);
      for (int i = 1; i < 6; i++) expect_out(i + 1, {2'b00, sel[i]});
      expect_out(8, {2'b00, byte_lane_write_1_n});
      @(negedge clk);
      expect_out(7, {2'b00, transfer_ack_n & card_channel_ready_n});
      -> chk_ev;
    end
    // Card answers promptly, then three cycles late
    for (int k = 0; k < 2; k++)
    begin
      tick(1);
      {sel, transfer_ack_n, card_hold} = {6'h3f, 1'b1, 4'(3 * k)};
      tick(1);
      sel = 6'h3d;
      for (int j = 0; j < 5; j++)
      begin
        @(negedge clk);
        expect_out(7, {2'b00, !(j < 3 * k)});
        -> chk_ev;
      end
    end
    tick(1);
    sel = 6'h3f;
    master_reset_n = 1'b0;
    wait_for(10, 3'h0, 10);
    tick(1);
    master_reset_n = 1'b1;
    wait_for(10, 3'h1, 40);
    tick(1);
    {wake_request_n, standby_request_n} = 2'b00;
    tick(10);
    expect_out(16, MBS_RUN);
    expect_out(9, 3'h0);
    settle();
    tick(1);
    wake_request_n = 1'b1;
    tick(8);
    standby_request_n = 1'b1;
    tick(8);
    standby_request_n = 1'b0;
    wait_for(16, MBS_STANDBY, 10);
    expect_out(11, 3'h1);
    settle();
    tick(1);
    standby_request_n = 1'b1;
    tick(8);
    wake_request_n = 1'b0;
    wait_for(16, MBS_RUN, 10);
    expect_out(11, 3'h0);
    settle();
    tick(1);
    wake_request_n = 1'b1;
    suspend_request_n = 1'b0;
    wait_for(16, MBS_SUSPEND, 10);
    tick(1);
    suspend_request_n = 1'b1;
    internal_wake = 1'b1;
    wait_for(16, MBS_RUN, 10);
    tick(1);
    internal_wake = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      {phy_tx_active, phy_rx_active, phy_collision} = 3'b001 << i;
      wait_for(12, 3'h0, 10);
      tick(1);
      {phy_tx_active, phy_rx_active, phy_collision} = 3'b000;
      wait_for(12, 3'h1, 10);
      tick(1);
    end
    {phy_link_ok, script_abort_strap} = 2'b10;
    wait_for(13, 3'h0, 10);
    wait_for(15, 3'h0, 10);
    tick(1);
    {phy_link_ok, script_abort_strap} = 2'b01;
    wait_for(13, 3'h1, 10);
    wait_for(15, 3'h1, 10);
    tick(1);
    {boot_drive, debug_drive} = 4'b1001;
    do_reset();
    wait_for(14, 3'h1, 10);
    tick(1);
    sel = 6'h3e;
    expect_out(0, 3'h1);
    expect_out(1, 3'h0);
    settle();
    tick(1);
    end_of_test();
  end
endmodule
